// ### include/gpio_port_pkg.sv
// Package with register map, reset values and field positions of the GPIO port
package gpio_port_pkg;
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 4;
  // Register offsets
  localparam logic [3:0] OFF_DATA      = 4'h0;
  localparam logic [3:0] OFF_DIR       = 4'h1;
  localparam logic [3:0] OFF_IRQ_SC    = 4'h2;
  localparam logic [3:0] OFF_POLARITY  = 4'h3;
  localparam logic [3:0] OFF_PULL_EN   = 4'h4;
  localparam logic [3:0] OFF_IRQ_SEL   = 4'h5;
  localparam logic [3:0] OFF_PWR_SC    = 4'h6;
  localparam logic [3:0] OFF_EVT_STAT  = 4'h7;
  localparam logic [3:0] OFF_EVT_CLR   = 4'h8;
  localparam logic [3:0] OFF_EVT_EN    = 4'h9;
  // Fields of the pin interrupt status/control register
  localparam int unsigned SC_MODE_BIT  = 0;
  localparam int unsigned SC_IE_BIT    = 1;
  localparam int unsigned SC_ACK_BIT   = 2;
  localparam int unsigned SC_FLAG_BIT  = 3;
  // Fields of the power mode status/control register
  localparam int unsigned PWR_ACK_BIT  = 0;
  localparam int unsigned PWR_FLAG_BIT = 1;
  localparam int unsigned PWR_STOP_BIT = 2;
  // Fields of the event status, clear and enable registers
  localparam int unsigned EVT_PIN_BIT  = 0;
  localparam int unsigned EVT_PPD_BIT  = 1;
  localparam int unsigned EVT_WIDTH    = 2;
  // Reset values
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [1:0] RESET_EVT     = 2'h0;
  localparam logic [7:0] READ_ZERO     = 8'h00;
  // Synchroniser depth
  localparam int unsigned SYNC_STAGES  = 2;
endpackage

// ### include/pin_irq_if.sv
// Interface joining the port top to its pin interrupt detector
`timescale 1ns/1ps
interface pin_irq_if #(parameter int unsigned W = 8);
  logic [W-1:0] pins_sync;
  logic [W-1:0] irq_sel;
  logic [W-1:0] polarity;
  logic         level_mode;
  logic         ack_write;
  logic         flag;
  logic         set_pulse;
  modport port (output pins_sync, output irq_sel, output polarity, output level_mode,
                output ack_write, input flag, input set_pulse);
  modport det  (input pins_sync, input irq_sel, input polarity, input level_mode,
                input ack_write, output flag, output set_pulse);
endinterface

// ### logic/gpio_port.sv
// Eight-bit GPIO port with pin interrupt, pulls, stop retention and register port
//
// Summary of operation
// - Enabled pin edge or level sets flag
// - Flag and enable raise interrupt request
// - Ack clears flag if enabled pins deasserted
// - Ack ignored while enabled pin asserted
// - Pull enable turns on pin resistor of input bits only
// - Polarity 0 pull-up, 1 pull-down
// - Spurious flag on enabling is clearable
// - Partial power-down stop holds pad drivers
// - Retained-logic stop keeps all I/O state
// - Input bits read the pin level
// - Output bits read the latch
// - Data write latches all bits, outputs drive
// - Reset zeroes latch, pins stay undriven
// - Direction 0 input, 1 output; resets 0
`timescale 1ns/1ps
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int unsigned W = PORT_WIDTH
) (
  input  wire logic                  CLK_IN,          // Bus clock, 10 MHz
  input  wire logic                  RST_IN,          // Synchronous reset, active high
  input  wire logic [ADDR_WIDTH-1:0] ADDR_IN,         // Register address
  input  wire logic [7:0]            WDATA_IN,        // Write data
  input  wire logic                  WR_IN,           // Write strobe
  input  wire logic                  RD_IN,           // Read strobe
  output logic      [7:0]            RDATA_OUT,       // Read data, cycle after strobe
  input  wire logic [W-1:0]          PIN_IN,          // Pin levels from the pads
  output logic      [W-1:0]          PIN_OUT,         // Level driven on the pads
  output logic      [W-1:0]          PIN_OE_OUT,      // Pad driver enable, high drives
  output logic      [W-1:0]          PULL_UP_OUT,     // Pull-up enable per pad
  output logic      [W-1:0]          PULL_DOWN_OUT,   // Pull-down enable per pad
  output logic                       PIN_IRQ_OUT,     // Port interrupt request
  output logic                       IRQ_OUT,         // Block event interrupt, level
  input  wire logic                  STOP_ENTER_IN,   // Pulse: entering partial stop
  input  wire logic                  STOP_EXIT_IN,    // Pulse: leaving partial stop
  output logic                       STOP_HOLD_OUT    // Pads frozen for partial stop
);
  // Register state
  logic [W-1:0] latch_reg;
  logic [W-1:0] dir_reg;
  logic [W-1:0] polarity_reg;
  logic [W-1:0] pull_en_reg;
  logic [W-1:0] irq_sel_reg;
  logic         irq_en_reg;
  logic         level_mode_reg;
  logic         ppd_flag_reg;
  logic         stop_reg;
  logic         hold_reg;
  logic [EVT_WIDTH-1:0] evt_stat_reg;
  logic [EVT_WIDTH-1:0] evt_en_reg;
  logic [7:0]   rdata_reg;
  logic [W-1:0] pin_out_reg;
  logic [W-1:0] pin_oe_reg;
  logic [W-1:0] pull_up_reg;
  logic [W-1:0] pull_down_reg;
  logic         pin_irq_reg;
  logic         irq_reg;
  logic [W-1:0] sync_a_reg;
  logic [W-1:0] sync_b_reg;

  pin_irq_if #(.W(W)) irq_link ();

  // Decoded strobes
  wire wr_data   = WR_IN && (ADDR_IN == OFF_DATA);
  wire wr_dir    = WR_IN && (ADDR_IN == OFF_DIR);
  wire wr_sc     = WR_IN && (ADDR_IN == OFF_IRQ_SC);
  wire wr_pol    = WR_IN && (ADDR_IN == OFF_POLARITY);
  wire wr_pull   = WR_IN && (ADDR_IN == OFF_PULL_EN);
  wire wr_sel    = WR_IN && (ADDR_IN == OFF_IRQ_SEL);
  wire wr_pwr    = WR_IN && (ADDR_IN == OFF_PWR_SC);
  wire wr_evtclr = WR_IN && (ADDR_IN == OFF_EVT_CLR);
  wire wr_evten  = WR_IN && (ADDR_IN == OFF_EVT_EN);
  wire ppd_ack   = wr_pwr && WDATA_IN[PWR_ACK_BIT];

  // Next stop state; entry wins over exit, and a wake wins over the ack
  wire stop_next = STOP_ENTER_IN ? 1'b1 : (STOP_EXIT_IN ? 1'b0 : stop_reg);
  wire ppd_next  = STOP_EXIT_IN ? 1'b1 : (ppd_ack ? 1'b0 : ppd_flag_reg);
  // Registered copy so the freeze output leaves a flip-flop directly
  wire hold_next = stop_next | ppd_next;

  // Inputs read the synchronised pin, outputs read the latch
  wire [W-1:0] data_view = (dir_reg & latch_reg) | (~dir_reg & sync_b_reg);

  // Pad controls while running; pulls only on undriven bits
  wire [W-1:0] oe_live   = dir_reg;
  wire [W-1:0] pull_live = pull_en_reg & ~dir_reg;
  wire [W-1:0] up_live   = pull_live & ~polarity_reg;
  wire [W-1:0] down_live = pull_live & polarity_reg;

  // Event sources: new port flag, partial stop wake
  wire [EVT_WIDTH-1:0] evt_set = {STOP_EXIT_IN, irq_link.set_pulse};
  wire [EVT_WIDTH-1:0] evt_clr = wr_evtclr ? WDATA_IN[EVT_WIDTH-1:0] : RESET_EVT;

  wire [7:0] sc_view  = {4'h0, irq_link.flag, 1'b0, irq_en_reg, level_mode_reg};
  wire [7:0] pwr_view = {5'h00, stop_reg, ppd_flag_reg, 1'b0};
  wire [7:0] evt_stat_view = {6'h00, evt_stat_reg};
  wire [7:0] evt_en_view   = {6'h00, evt_en_reg};

  // Read mux; unmapped and write-only offsets read zero
  wire [7:0] rd_mux =
    (ADDR_IN == OFF_DATA)     ? data_view     :
    (ADDR_IN == OFF_DIR)      ? dir_reg       :
    (ADDR_IN == OFF_IRQ_SC)   ? sc_view       :
    (ADDR_IN == OFF_POLARITY) ? polarity_reg  :
    (ADDR_IN == OFF_PULL_EN)  ? pull_en_reg   :
    (ADDR_IN == OFF_IRQ_SEL)  ? irq_sel_reg   :
    (ADDR_IN == OFF_PWR_SC)   ? pwr_view      :
    (ADDR_IN == OFF_EVT_STAT) ? evt_stat_view :
    (ADDR_IN == OFF_EVT_EN)   ? evt_en_view   : READ_ZERO;

  // Detector hookup
  assign irq_link.pins_sync  = sync_b_reg;
  assign irq_link.irq_sel    = irq_sel_reg;
  assign irq_link.polarity   = polarity_reg;
  assign irq_link.level_mode = level_mode_reg;
  assign irq_link.ack_write  = wr_sc && WDATA_IN[SC_ACK_BIT];

  pin_irq_detect #(.W(W)) u_detect (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .irq    (irq_link)
  );

  // Two-stage pin synchroniser; only the second stage is read
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      sync_a_reg <= RESET_BYTE;
      sync_b_reg <= RESET_BYTE;
    end else begin
      sync_a_reg <= PIN_IN;
      sync_b_reg <= sync_a_reg;
    end
  end

  // Data latch takes every bit on a write regardless of direction
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      latch_reg <= RESET_BYTE;
      dir_reg   <= RESET_BYTE;
    end else begin
      if (wr_data)
        latch_reg <= WDATA_IN;
      if (wr_dir)
        dir_reg   <= WDATA_IN;
    end
  end

  // Interrupt configuration
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      polarity_reg   <= RESET_BYTE;
      pull_en_reg    <= RESET_BYTE;
      irq_sel_reg    <= RESET_BYTE;
      irq_en_reg     <= 1'b0;
      level_mode_reg <= 1'b0;
    end else begin
      if (wr_pol)
        polarity_reg <= WDATA_IN;
      if (wr_pull)
        pull_en_reg  <= WDATA_IN;
      if (wr_sel)
        irq_sel_reg  <= WDATA_IN;
      if (wr_sc) begin
        irq_en_reg     <= WDATA_IN[SC_IE_BIT];
        level_mode_reg <= WDATA_IN[SC_MODE_BIT];
      end
    end
  end

  // Partial stop state; the flag records a wake from it until acknowledged
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      stop_reg     <= 1'b0;
      ppd_flag_reg <= 1'b0;
      hold_reg     <= 1'b0;
    end else begin
      stop_reg     <= stop_next;
      ppd_flag_reg <= ppd_next;
      hold_reg     <= hold_next;
    end
  end

  // Sticky event bits; a set in the clear cycle wins
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      evt_stat_reg <= RESET_EVT;
      evt_en_reg   <= RESET_EVT;
    end else begin
      evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
      if (wr_evten)
        evt_en_reg <= WDATA_IN[EVT_WIDTH-1:0];
    end
  end

  // Pad drivers freeze during partial stop and until its flag is acknowledged,
  // so the pins keep their pre-stop levels while software restores state
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pin_out_reg   <= RESET_BYTE;
      pin_oe_reg    <= RESET_BYTE;
      pull_up_reg   <= RESET_BYTE;
      pull_down_reg <= RESET_BYTE;
    end else if (!(stop_reg || ppd_flag_reg)) begin
      pin_out_reg   <= latch_reg;
      pin_oe_reg    <= oe_live;
      pull_up_reg   <= up_live;
      pull_down_reg <= down_live;
    end
  end

  // Interrupt outputs and read data
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pin_irq_reg <= 1'b0;
      irq_reg     <= 1'b0;
      rdata_reg   <= READ_ZERO;
    end else begin
      pin_irq_reg <= irq_link.flag & irq_en_reg;
      irq_reg     <= |(evt_stat_reg & evt_en_reg);
      rdata_reg   <= RD_IN ? rd_mux : READ_ZERO;
    end
  end

  // Retained-logic stop needs nothing here: all state simply stays powered
  assign RDATA_OUT     = rdata_reg;
  assign PIN_OUT       = pin_out_reg;
  assign PIN_OE_OUT    = pin_oe_reg;
  assign PULL_UP_OUT   = pull_up_reg;
  assign PULL_DOWN_OUT = pull_down_reg;
  assign PIN_IRQ_OUT   = pin_irq_reg;
  assign IRQ_OUT       = irq_reg;
  assign STOP_HOLD_OUT = hold_reg;
endmodule

// ### logic/pin_irq_detect.sv
// Pin interrupt detector: edge or level detection and the port flag
`timescale 1ns/1ps
module pin_irq_detect
  import gpio_port_pkg::*;
#(
  parameter int unsigned W = PORT_WIDTH
) (
  input  wire logic  clk_in,   // Bus clock
  input  wire logic  rst_in,   // Synchronous reset, active high
  pin_irq_if.det     irq       // Link to the port
);
  logic [W-1:0] asserted;
  logic [W-1:0] prev_reg;
  logic [W-1:0] prev_next;
  logic [W-1:0] edge_hit;
  logic         any_asserted;
  logic         event_hit;
  logic         flag_reg;
  logic         flag_next;
  logic         pulse_reg;

  // Polarity bit 1 makes high/rising the asserted sense, 0 makes low/falling
  assign asserted     = ~(irq.pins_sync ^ irq.polarity) & irq.irq_sel;
  assign prev_next    = asserted;
  assign edge_hit     = asserted & ~prev_reg;
  assign any_asserted = |asserted;
  // Level mode keeps firing while asserted; edge mode only on a fresh assert
  assign event_hit    = irq.level_mode ? any_asserted : |edge_hit;
  // Set wins over acknowledge; ack blocked while any enabled pin asserted
  assign flag_next    = event_hit ? 1'b1 :
                        (irq.ack_write && !any_asserted) ? 1'b0 :
                        flag_reg;
  assign irq.flag      = flag_reg;
  assign irq.set_pulse = pulse_reg;

  // Enabling a pin whose level is already asserted counts as an edge; the ack clears it once the pin deasserts
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_reg  <= '0;
      flag_reg  <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      prev_reg  <= prev_next;
      flag_reg  <= flag_next;
      pulse_reg <= event_hit & ~flag_reg;
    end
  end
endmodule

// ### tb/gpio_port_checker.sv
// Port-level assertions for the GPIO port
`timescale 1ns/1ps
module gpio_port_checker
  import gpio_port_pkg::*;
#(
  parameter int unsigned W = PORT_WIDTH
) (
  input wire logic                  CLK_IN,        // Clock
  input wire logic                  RST_IN,        // Reset
  input wire logic [ADDR_WIDTH-1:0] ADDR_IN,       // Address
  input wire logic [7:0]            WDATA_IN,      // Write data
  input wire logic                  WR_IN,         // Write strobe
  input wire logic                  RD_IN,         // Read strobe
  input wire logic [7:0]            RDATA_OUT,     // Read data
  input wire logic [W-1:0]          PIN_OUT,       // Pad level
  input wire logic [W-1:0]          PIN_OE_OUT,    // Pad enable
  input wire logic [W-1:0]          PULL_UP_OUT,   // Pull-ups
  input wire logic [W-1:0]          PULL_DOWN_OUT, // Pull-downs
  input wire logic                  PIN_IRQ_OUT,   // Port request
  input wire logic                  IRQ_OUT,       // Event request
  input wire logic                  STOP_ENTER_IN, // Stop entry
  input wire logic                  STOP_HOLD_OUT  // Pad freeze
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // Write decodes that are the only legal causes of a falling request or freeze
  wire sc_wr   = WR_IN && ADDR_IN == OFF_IRQ_SC;
  wire evt_wr  = WR_IN && (ADDR_IN == OFF_EVT_CLR || ADDR_IN == OFF_EVT_EN);
  wire pwr_ack = WR_IN && ADDR_IN == OFF_PWR_SC && WDATA_IN[PWR_ACK_BIT];
  // Stop entry is answered by the pad freeze one edge later
  sequence s_enter;
    STOP_ENTER_IN ##1 STOP_HOLD_OUT;
  endsequence
  a_read_idle: assert property (!RD_IN |=> RDATA_OUT == READ_ZERO)
    else $error("read data not cleared");
  a_unmapped_read: assert property (RD_IN && (ADDR_IN == OFF_EVT_CLR ||
    ADDR_IN > OFF_EVT_EN) |=> RDATA_OUT == READ_ZERO) else $error("empty read not zero");
  a_reset_quiet: assert property ($fell(RST_IN) |-> !PIN_IRQ_OUT && !IRQ_OUT &&
    (PIN_OE_OUT | PULL_UP_OUT | PULL_DOWN_OUT) == '0) else $error("outputs live after reset");
  a_pull_exclusive: assert property (((PULL_UP_OUT & PULL_DOWN_OUT) |
    ((PULL_UP_OUT | PULL_DOWN_OUT) & PIN_OE_OUT)) == '0) else $error("pull clash");
  a_enter_hold: assert property (STOP_ENTER_IN |-> s_enter)
    else $error("no freeze on stop");
  a_hold_stays: assert property (STOP_HOLD_OUT && !pwr_ack |=> STOP_HOLD_OUT)
    else $error("freeze lost without ack");
  a_pads_frozen: assert property (STOP_HOLD_OUT && $past(STOP_HOLD_OUT) |->
    $stable(PIN_OUT) && $stable(PIN_OE_OUT)) else $error("pads moved while frozen");
  a_flag_drop: assert property ($fell(PIN_IRQ_OUT) |-> $past(sc_wr, 2))
    else $error("port request fell without write");
  a_irq_drop: assert property ($fell(IRQ_OUT) |-> $past(evt_wr, 2))
    else $error("event request fell without write");
endmodule
bind gpio_port gpio_port_checker #(.W(W)) u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT),
  .PULL_UP_OUT(PULL_UP_OUT), .PULL_DOWN_OUT(PULL_DOWN_OUT), .PIN_IRQ_OUT(PIN_IRQ_OUT),
  .IRQ_OUT(IRQ_OUT), .STOP_ENTER_IN(STOP_ENTER_IN), .STOP_HOLD_OUT(STOP_HOLD_OUT));

// ### tb/pad_model.sv
// Pad model: external sources, pull resistors and floating pads
`timescale 1ns/1ps
module pad_model #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_in,     // Clock for floating pattern
  input  wire logic [W-1:0] drive_in,   // Level from the port
  input  wire logic [W-1:0] oe_in,      // Port driver enable
  input  wire logic [W-1:0] pull_up_in, // Pull-up enable
  input  wire logic [W-1:0] pull_dn_in, // Pull-down enable
  input  wire logic [W-1:0] ext_in,     // External source level
  input  wire logic [W-1:0] ext_en_in,  // External source enable
  output logic      [W-1:0] pad_out     // Resolved pad level
);
  logic [W-1:0] float_reg = '0;
  // An open pad wanders so a stale level is never read back
  always_ff @(posedge clk_in) begin
    float_reg <= ~float_reg;
  end
  // Port driver wins, then the outside source, then the resistors
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe_in[i]) begin
        pad_out[i] = drive_in[i];
      end else if (ext_en_in[i]) begin
        pad_out[i] = ext_in[i];
      end else if (pull_up_in[i]) begin
        pad_out[i] = 1'b1;
      end else if (pull_dn_in[i]) begin
        pad_out[i] = 1'b0;
      end else begin
        pad_out[i] = float_reg[i];
      end
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the GPIO port
`timescale 1ns/1ps
module tb_top;
  import gpio_port_pkg::*;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       s_in = 1'b0;
  logic       s_out = 1'b0;
  logic [7:0] ext = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] rdata, pin_in, pin_out, oe, pu, pd;
  logic       pin_irq, irq, hold;
  int         fails = 0;
  int         checks = 0;
  int         n;
  // Register cases: address, value written, value read back
  row_s rows[11] = '{'{OFF_EVT_STAT, 8'hFF, 8'h00}, '{OFF_EVT_CLR, 8'hFF, 8'h00},
    '{4'hA, 8'hFF, 8'h00}, '{4'hF, 8'h12, 8'h00}, '{OFF_PWR_SC, 8'h00, 8'h00},
    '{OFF_IRQ_SC, 8'h03, 8'h03}, '{OFF_DIR, 8'h3C, 8'h3C}, '{OFF_POLARITY, 8'hA5, 8'hA5},
    '{OFF_PULL_EN, 8'h5A, 8'h5A}, '{OFF_EVT_EN, 8'h03, 8'h03}, '{OFF_IRQ_SEL, 8'h81, 8'h81}};
  // Bench clock, 100 ns period
  always #50 clk = ~clk;
  gpio_port dut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_OUT(oe),
    .PULL_UP_OUT(pu), .PULL_DOWN_OUT(pd), .PIN_IRQ_OUT(pin_irq), .IRQ_OUT(irq),
    .STOP_ENTER_IN(s_in), .STOP_EXIT_IN(s_out), .STOP_HOLD_OUT(hold));
  pad_model pads (.clk_in(clk), .drive_in(pin_out), .oe_in(oe), .pull_up_in(pu),
    .pull_dn_in(pd), .ext_in(ext), .ext_en_in(ext_en), .pad_out(pin_in));
  // Compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One-cycle bus write
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle bus read; data is looked at only in the following cycle
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
  endtask
  // Event request after its one-cycle lag
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic pulse_stop(input logic exit);
    @(posedge clk);
    if (exit) s_out <= 1'b1; else s_in <= 1'b1;
    @(posedge clk);
    s_out <= 1'b0;
    s_in <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, 8'hFF, rows[i].e);
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk(oe | pu | pd, 8'h00);
    rd_reg(OFF_DIR, 8'hFF, 8'h00);
    rd_reg(OFF_PULL_EN, 8'hFF, 8'h00);
    rd_reg(OFF_IRQ_SEL, 8'hFF, 8'h00);
    // Mixed directions: low nibble read from pulled pads
    wr_reg(OFF_DIR, 8'hF0);
    wr_reg(OFF_DATA, 8'hA5);
    wr_reg(OFF_PULL_EN, 8'hFF);
    wr_reg(OFF_POLARITY, 8'h03);
    repeat (4) @(posedge clk);
    rd_reg(OFF_DATA, 8'hFF, 8'hAC);
    chk(oe, 8'hF0);
    chk(pin_out & 8'hF0, 8'hA0);
    chk(pd, 8'h03);
    chk(pu, 8'h0C);
    // Pin interrupt on pin 0, rising asserted, set up in the safe order
    wr_reg(OFF_IRQ_SC, 8'h00);
    wr_reg(OFF_IRQ_SEL, 8'h01);
    wr_reg(OFF_IRQ_SC, 8'h04);
    wr_reg(OFF_IRQ_SC, 8'h02);
    wr_reg(OFF_EVT_EN, 8'h01);
    ext <= 8'h03;
    ext_en <= 8'h01;
    for (n = 0; n < 10 && pin_irq !== 1'b1; n++) @(negedge clk);
    chk({7'h00, pin_irq}, 8'h01);
    irq_is(1'b1);
    rd_reg(OFF_EVT_STAT, 8'h01, 8'h01);
    wr_reg(OFF_IRQ_SC, 8'h06);
    rd_reg(OFF_IRQ_SC, 8'h08, 8'h08);
    ext_en <= 8'h00;
    repeat (4) @(posedge clk);
    wr_reg(OFF_IRQ_SC, 8'h06);
    rd_reg(OFF_IRQ_SC, 8'h08, 8'h00);
    chk({7'h00, pin_irq}, 8'h00);
    // Event interrupt: sticky, masked, cleared
    wr_reg(OFF_EVT_EN, 8'h00);
    irq_is(1'b0);
    wr_reg(OFF_EVT_EN, 8'h01);
    irq_is(1'b1);
    wr_reg(OFF_EVT_CLR, 8'h01);
    irq_is(1'b0);
    // Enabling an already asserted pin may flag; the flag must clear
    ext_en <= 8'h02;
    repeat (4) @(posedge clk);
    wr_reg(OFF_IRQ_SEL, 8'h03);
    repeat (3) @(posedge clk);
    rd_reg(OFF_IRQ_SC, 8'h08, 8'h08);
    ext_en <= 8'h00;
    repeat (4) @(posedge clk);
    wr_reg(OFF_IRQ_SC, 8'h06);
    rd_reg(OFF_IRQ_SC, 8'h08, 8'h00);
    // Level mode, low asserted: flag follows a held low level
    wr_reg(OFF_POLARITY, 8'h00);
    repeat (5) @(posedge clk);
    wr_reg(OFF_IRQ_SC, 8'h07);
    rd_reg(OFF_IRQ_SC, 8'h08, 8'h00);
    ext <= 8'h00;
    ext_en <= 8'h01;
    repeat (5) @(posedge clk);
    rd_reg(OFF_IRQ_SC, 8'h08, 8'h08);
    wr_reg(OFF_IRQ_SC, 8'h07);
    rd_reg(OFF_IRQ_SC, 8'h08, 8'h08);
    ext_en <= 8'h00;
    repeat (5) @(posedge clk);
    wr_reg(OFF_IRQ_SC, 8'h07);
    rd_reg(OFF_IRQ_SC, 8'h08, 8'h00);
    chk({7'h00, pin_irq}, 8'h00);
    wr_reg(OFF_IRQ_SEL, 8'h00);
    // Partial stop: pads hold until software restores and acknowledges
    wr_reg(OFF_DIR, 8'hFF);
    wr_reg(OFF_DATA, 8'h5A);
    pulse_stop(1'b0);
    pulse_stop(1'b1);
    rd_reg(OFF_PWR_SC, 8'h02, 8'h02);
    rd_reg(OFF_EVT_STAT, 8'h02, 8'h02);
    wr_reg(OFF_DATA, 8'h00);
    repeat (2) @(negedge clk);
    chk(pin_out, 8'h5A);
    wr_reg(OFF_PWR_SC, 8'h01);
    repeat (3) @(negedge clk);
    chk({7'h00, hold}, 8'h00);
    chk(pin_out, 8'h00);
    wrap_up();
  end
endmodule
